// *** verilog/oseb_pkg.sv ***
// constants shared by the operation-status event bank
// assumes a 100 MHz instrument clock and a command decoder on the same clock
package oseb_pkg;

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int SUBREG_COUNT = 30;
	localparam int GROUP_SIZE = 15;
	localparam int REG_W = 16;
	localparam logic [4:0] GROUP_SPAN = 5'h0F;
	localparam logic [4:0] MEMBER_BASE = 5'h01;

	// ----------------------------------------
	// bit positions
	// ----------------------------------------
	localparam logic [3:0] BIT_OVERLOAD = 4'h0;
	localparam logic [3:0] BIT_INVALID = 4'h4;
	localparam logic [3:0] BIT_UNLOCK = 4'h6;
	localparam logic [3:0] BIT_OVERDRIVE = 4'hB;
	localparam logic [3:0] BIT_UNDERDRIVE = 4'hC;
	localparam logic [3:0] OPER_BIT_FIRST_SUMMARY_GROUP = 4'h8;
	localparam logic [3:0] OPER_BIT_SECOND_SUMMARY_GROUP = 4'h9;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [15:0] PTR_RESET = 16'hFFFF;
	localparam logic [15:0] NTR_RESET = 16'h0000;
	localparam logic [15:0] EN_RESET = 16'h0000;

	// ----------------------------------------
	// function groups, operations, targets, parts, symbols
	// ----------------------------------------
	localparam logic [1:0] FUNC_NONE = 2'h0;
	localparam logic [1:0] FUNC_BASE = 2'h1;
	localparam logic [1:0] FUNC_RFNS = 2'h2;
	localparam logic [1:0] FUNC_OTHER = 2'h3;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_SYM_ENABLE = 2'h2;
	localparam logic [1:0] OP_SYM_READ = 2'h3;
	localparam logic [2:0] TGT_SUBREG = 3'h0;
	localparam logic [2:0] TGT_FIRST_SUMMARY_GROUP = 3'h1;
	localparam logic [2:0] TGT_SECOND_SUMMARY_GROUP = 3'h2;
	localparam logic [2:0] TGT_OPER = 3'h3;
	localparam logic [2:0] TGT_QUES = 3'h4;
	localparam logic [2:0] PART_EVENT = 3'h0;
	localparam logic [2:0] PART_COND = 3'h1;
	localparam logic [2:0] PART_PTR = 3'h2;
	localparam logic [2:0] PART_NTR = 3'h3;
	localparam logic [2:0] PART_ENABLE = 3'h4;
	localparam logic [2:0] SYM_INVALID = 3'h0;
	localparam logic [2:0] SYM_UNLOCK = 3'h1;
	localparam logic [2:0] SYM_OVERLOAD = 3'h2;
	localparam logic [2:0] SYM_OVERDRIVE = 3'h3;
	localparam logic [2:0] SYM_UNDERDRIVE = 3'h4;

	// ----------------------------------------
	// source pin order after synchronising
	// ----------------------------------------
	localparam int SRC_COUNT = 6;
	localparam int SRC_INV_BASE = 0;
	localparam int SRC_INV_RF = 1;
	localparam int SRC_OVERLOAD = 2;
	localparam int SRC_OVERDRIVE = 3;
	localparam int SRC_UNDERDRIVE = 4;
	localparam int SRC_UNLOCK = 5;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int LOCK_CHECK_MS = 1000;
	localparam int LOCK_CHECK_CYCLES = CLK_HZ / 1000 * LOCK_CHECK_MS;

endpackage

// *** verilog/oseb_sync.sv ***
// two-flop synchroniser for a vector of independent level pins
// assumes each bit is a slow level; no bus coherency between bits
`timescale 1ns/1ps
module oseb_sync #(
	parameter int W = 6
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} oseb_sync_t;

	oseb_sync_t st_reg;
	oseb_sync_t st_next;

	always_comb begin
		st_next.s1 = pin_i;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign level_o = st_reg.s2;
endmodule

// *** verilog/oseb_tick.sv ***
// divider giving a one-cycle enable every CYCLES clocks
// assumes CYCLES of at least 2
`timescale 1ns/1ps
module oseb_tick #(
	parameter int CYCLES = 100_000_000
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	output logic tick_o
);
	typedef struct packed {
		logic [31:0] count;
		logic tick;
	} oseb_tick_t;

	localparam logic [31:0] LAST = 32'(CYCLES - 1);

	oseb_tick_t st_reg;
	oseb_tick_t st_next;

	always_comb begin
		st_next.tick = (st_reg.count == LAST);
		st_next.count = st_next.tick ? 32'h0000_0000 : st_reg.count + 32'h0000_0001;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick_o = st_reg.tick;
endmodule

// *** verilog/oseb_bank.sv ***
// operation-status event bank: 30 sub-registers in two summary groups
// assumes command decoder on clk_i; event source pins are asynchronous
`timescale 1ns/1ps

//Contract
// - thirty sub-registers, two groups, indexed by member
// - unbound sub-registers never set bits
// - event part accumulates between readouts
// - all five parts readable by query
// - base system fixed at first member
// - bit 4 flags invalid measurement
// - bit 6 unlock, rechecked once per second
// - rf bit 0 flags connector overload
// - rf bit 11 flags overdrive
// - rf bit 12 while underdriven
// - symbols map to bits of current sub-register
// - questionable register present, always zero
// - summary bit from enabled operation events
module oseb_bank #(
	parameter int LOCK_CHECK_CYCLES_P = oseb_pkg::LOCK_CHECK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic invalid_base_i,
	input wire logic invalid_rf_i,
	input wire logic overload_i,
	input wire logic overdrive_i,
	input wire logic underdrive_i,
	input wire logic ref_unlocked_i,
	input wire logic bind_valid_i,
	input wire logic bind_group_i,
	input wire logic [3:0] bind_member_i,
	input wire logic [1:0] bind_func_i,
	input wire logic clear_status_i,
	input wire logic query_valid_i,
	input wire logic [1:0] query_op_i,
	input wire logic [2:0] query_target_i,
	input wire logic [2:0] query_part_i,
	input wire logic query_group_i,
	input wire logic [3:0] query_member_i,
	input wire logic [2:0] query_symbol_i,
	input wire logic [oseb_pkg::REG_W-1:0] query_wdata_i,
	output logic [oseb_pkg::REG_W-1:0] query_rdata_o,
	output logic query_ack_o,
	output logic query_error_o,
	output logic oper_summary_o,
	output logic reference_unlocked_flag_o
);
	import oseb_pkg::*;

	typedef struct packed {
		logic [SUBREG_COUNT-1:0][REG_W-1:0] event_bits;
		logic [SUBREG_COUNT-1:0][REG_W-1:0] cond_bits;
		logic [SUBREG_COUNT-1:0][REG_W-1:0] ptr_bits;
		logic [SUBREG_COUNT-1:0][REG_W-1:0] ntr_bits;
		logic [SUBREG_COUNT-1:0][REG_W-1:0] en_bits;
		logic [SUBREG_COUNT-1:0][1:0] func;
		logic [REG_W-1:0] oper_en;
		logic [1:0][REG_W-1:0] sum_en;
		logic [REG_W-1:0] rdata;
		logic ack;
		logic err;
		logic sum_bit;
		logic lock_fail;
	} oseb_state_t;

	oseb_state_t st_reg;
	oseb_state_t st_next;

	logic [SRC_COUNT-1:0] src_s;
	logic tick;
	logic [SUBREG_COUNT-1:0][REG_W-1:0] cond_now;
	logic [SUBREG_COUNT-1:0][REG_W-1:0] edge_now;
	logic [SUBREG_COUNT-1:0] member_hit;
	logic [1:0][REG_W-1:0] sum_ev;
	logic [REG_W-1:0] oper_ev;
	logic oper_hit;
	logic [4:0] q_idx;
	logic [4:0] b_idx;
	logic q_ok;
	logic b_ok;
	logic rd_event;
	logic sym_ok;
	logic [3:0] sym_pos;

	// ----------------------------------------
	// pins and once-per-second lock check
	// ----------------------------------------
	oseb_sync #(.W(SRC_COUNT)) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.pin_i({ref_unlocked_i, underdrive_i, overdrive_i, overload_i, invalid_rf_i, invalid_base_i}),
		.level_o(src_s)
	);

	oseb_tick #(.CYCLES(LOCK_CHECK_CYCLES_P)) u_tick (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_o(tick)
	);

	// ----------------------------------------
	// per sub-register condition, edge and summary
	// ----------------------------------------
	function automatic logic [REG_W-1:0] cond_of(input logic [1:0] f, input logic [SRC_COUNT-1:0] s,
		input logic lk);
		logic [REG_W-1:0] c;
		c = '0;
		if (f == FUNC_BASE) begin
			c[BIT_INVALID] = s[SRC_INV_BASE];
			c[BIT_UNLOCK] = lk;
		end else if (f == FUNC_RFNS) begin
			c[BIT_OVERLOAD] = s[SRC_OVERLOAD];
			c[BIT_INVALID] = s[SRC_INV_RF];
			c[BIT_OVERDRIVE] = s[SRC_OVERDRIVE];
			c[BIT_UNDERDRIVE] = s[SRC_UNDERDRIVE];
		end
		return c;
	endfunction

	// optional function groups bind but report nothing here
	genvar gi;
	generate
		for (gi = 0; gi < SUBREG_COUNT; gi++) begin : g_sub
			assign cond_now[gi] = cond_of(st_reg.func[gi], src_s, st_reg.lock_fail);
			assign edge_now[gi] = (st_reg.func[gi] == FUNC_NONE) ? '0 :
				((cond_now[gi] & ~st_reg.cond_bits[gi] & st_reg.ptr_bits[gi]) |
				(~cond_now[gi] & st_reg.cond_bits[gi] & st_reg.ntr_bits[gi]));
			assign member_hit[gi] = |(st_reg.event_bits[gi] & st_reg.en_bits[gi]);
		end
	endgenerate

	// summary bit n reports member n; bit 0 unused
	assign sum_ev[0] = {member_hit[GROUP_SIZE-1:0], 1'b0};
	assign sum_ev[1] = {member_hit[SUBREG_COUNT-1:GROUP_SIZE], 1'b0};
	always_comb begin
		oper_ev = '0;
		oper_ev[OPER_BIT_FIRST_SUMMARY_GROUP] = |(sum_ev[0] & st_reg.sum_en[0]);
		oper_ev[OPER_BIT_SECOND_SUMMARY_GROUP] = |(sum_ev[1] & st_reg.sum_en[1]);
	end
	assign oper_hit = |(oper_ev & st_reg.oper_en);

	// ----------------------------------------
	// addressing and symbol map
	// ----------------------------------------
	assign q_idx = 5'({1'b0, query_member_i} - MEMBER_BASE) + (query_group_i ? GROUP_SPAN : 5'h00);
	assign b_idx = 5'({1'b0, bind_member_i} - MEMBER_BASE) + (bind_group_i ? GROUP_SPAN : 5'h00);
	assign q_ok = (query_member_i != 4'h0);
	assign b_ok = (bind_member_i != 4'h0) && (b_idx != 5'h00);
	assign rd_event = query_valid_i && q_ok && ((query_op_i == OP_SYM_READ) ||
		(query_op_i == OP_READ && query_target_i == TGT_SUBREG && query_part_i == PART_EVENT));

	always_comb begin
		sym_ok = 1'b1;
		case (query_symbol_i)
			SYM_INVALID: sym_pos = BIT_INVALID;
			SYM_UNLOCK: sym_pos = BIT_UNLOCK;
			SYM_OVERLOAD: sym_pos = BIT_OVERLOAD;
			SYM_OVERDRIVE: sym_pos = BIT_OVERDRIVE;
			SYM_UNDERDRIVE: sym_pos = BIT_UNDERDRIVE;
			default: begin
				sym_pos = BIT_INVALID;
				sym_ok = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.ack = 1'b0;
		st_next.err = 1'b0;
		st_next.sum_bit = oper_hit;
		if (tick) begin
			st_next.lock_fail = src_s[SRC_UNLOCK];
		end
		for (int i = 0; i < SUBREG_COUNT; i++) begin
			st_next.cond_bits[i] = cond_now[i];
			// a new edge wins over a clear in the same cycle
			if (clear_status_i || (rd_event && q_idx == 5'(i))) begin
				st_next.event_bits[i] = edge_now[i];
			end else begin
				st_next.event_bits[i] = st_reg.event_bits[i] | edge_now[i];
			end
		end
		if (bind_valid_i && b_ok) begin
			st_next.func[b_idx] = bind_func_i;
			st_next.event_bits[b_idx] = '0;
		end
		st_next.func[0] = FUNC_BASE;
		if (query_valid_i) begin
			st_next.ack = 1'b1;
			st_next.rdata = '0;
			case (query_op_i)
				OP_READ: begin
					case (query_target_i)
						TGT_SUBREG: begin
							st_next.err = !q_ok;
							case (query_part_i)
								PART_EVENT: st_next.rdata = st_reg.event_bits[q_idx];
								PART_COND: st_next.rdata = st_reg.cond_bits[q_idx];
								PART_PTR: st_next.rdata = st_reg.ptr_bits[q_idx];
								PART_NTR: st_next.rdata = st_reg.ntr_bits[q_idx];
								PART_ENABLE: st_next.rdata = st_reg.en_bits[q_idx];
								default: st_next.err = 1'b1;
							endcase
							if (!q_ok) begin
								st_next.rdata = '0;
							end
						end
						TGT_FIRST_SUMMARY_GROUP, TGT_SECOND_SUMMARY_GROUP: begin
							if (query_part_i == PART_ENABLE) begin
								st_next.rdata = st_reg.sum_en[query_target_i == TGT_SECOND_SUMMARY_GROUP];
							end else if (query_part_i == PART_EVENT || query_part_i == PART_COND) begin
								st_next.rdata = sum_ev[query_target_i == TGT_SECOND_SUMMARY_GROUP];
							end
						end
						TGT_OPER: begin
							if (query_part_i == PART_ENABLE) begin
								st_next.rdata = st_reg.oper_en;
							end else if (query_part_i == PART_EVENT || query_part_i == PART_COND) begin
								st_next.rdata = oper_ev;
							end
						end
						TGT_QUES: st_next.rdata = '0;
						default: st_next.err = 1'b1;
					endcase
				end
				OP_WRITE: begin
					if (query_target_i == TGT_SUBREG && q_ok && query_part_i == PART_PTR) begin
						st_next.ptr_bits[q_idx] = query_wdata_i;
					end else if (query_target_i == TGT_SUBREG && q_ok && query_part_i == PART_NTR) begin
						st_next.ntr_bits[q_idx] = query_wdata_i;
					end else if (query_target_i == TGT_SUBREG && q_ok && query_part_i == PART_ENABLE) begin
						st_next.en_bits[q_idx] = query_wdata_i;
					end else if ((query_target_i == TGT_FIRST_SUMMARY_GROUP || query_target_i == TGT_SECOND_SUMMARY_GROUP) &&
						query_part_i == PART_ENABLE) begin
						st_next.sum_en[query_target_i == TGT_SECOND_SUMMARY_GROUP] = query_wdata_i;
					end else if (query_target_i == TGT_OPER && query_part_i == PART_ENABLE) begin
						st_next.oper_en = query_wdata_i;
					end else if (query_target_i != TGT_QUES) begin
						st_next.err = 1'b1;
					end
				end
				OP_SYM_ENABLE: begin
					if (q_ok && sym_ok) begin
						st_next.en_bits[q_idx][sym_pos] = 1'b1;
						st_next.sum_en[query_group_i][query_member_i] = 1'b1;
						st_next.oper_en[query_group_i ? OPER_BIT_SECOND_SUMMARY_GROUP : OPER_BIT_FIRST_SUMMARY_GROUP] = 1'b1;
					end else begin
						st_next.err = 1'b1;
					end
				end
				OP_SYM_READ: begin
					st_next.rdata = q_ok ? st_reg.event_bits[q_idx] : '0;
					st_next.err = !q_ok;
				end
				default: st_next.err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
			st_reg.ptr_bits <= {SUBREG_COUNT{PTR_RESET}};
			st_reg.ntr_bits <= {SUBREG_COUNT{NTR_RESET}};
			st_reg.en_bits <= {SUBREG_COUNT{EN_RESET}};
			st_reg.func[0] <= FUNC_BASE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign query_rdata_o = st_reg.rdata;
	assign query_ack_o = st_reg.ack;
	assign query_error_o = st_reg.err;
	assign oper_summary_o = st_reg.sum_bit;
	assign reference_unlocked_flag_o = st_reg.lock_fail;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	base_bound_a: assert property (st_reg.func[0] == FUNC_BASE)
		else $error("base sub-register not bound to base system");
	unbound_quiet_a: assert property ($past(st_reg.func[3]) == FUNC_NONE && st_reg.func[3] == FUNC_NONE
		|-> st_reg.event_bits[3] == '0)
		else $error("unbound sub-register holds events");
	invalid_latch_a: assert property (edge_now[0][BIT_INVALID] |=> st_reg.event_bits[0][BIT_INVALID])
		else $error("invalid result edge not latched");
	lock_hold_a: assert property (!tick |=> $stable(st_reg.lock_fail))
		else $error("lock flag changed between checks");
	lock_sample_a: assert property (tick |=> st_reg.lock_fail == $past(src_s[SRC_UNLOCK]) &&
		st_reg.cond_bits[0][BIT_UNLOCK] == $past(st_reg.lock_fail))
		else $error("lock flag not sampled at check");
	rf_map_a: assert property (st_reg.func[17] == FUNC_RFNS |=>
		st_reg.cond_bits[17][BIT_OVERLOAD] == $past(src_s[SRC_OVERLOAD]) &&
		st_reg.cond_bits[17][BIT_OVERDRIVE] == $past(src_s[SRC_OVERDRIVE]) &&
		st_reg.cond_bits[17][BIT_UNDERDRIVE] == $past(src_s[SRC_UNDERDRIVE]))
		else $error("rf condition bits misplaced");
	summary_bit_a: assert property (##1 oper_summary_o == $past(oper_hit))
		else $error("summary bit does not follow enabled events");
	ques_zero_a: assert property (query_valid_i && query_op_i == OP_READ && query_target_i == TGT_QUES
		|=> query_ack_o && query_rdata_o == '0)
		else $error("questionable register not zero");
	read_clear_a: assert property (rd_event && q_idx == 5'h00 && edge_now[0] == '0
		|=> st_reg.event_bits[0] == '0)
		else $error("event part not cleared by read");
	answer_a: assert property (query_valid_i |=> query_ack_o ##1 (query_ack_o == $past(query_valid_i)))
		else $error("query not answered in one cycle");
	sym_enable_a: assert property (query_valid_i && query_op_i == OP_SYM_ENABLE && q_idx == 5'h11 && q_ok
		&& query_symbol_i == SYM_OVERLOAD |=> st_reg.en_bits[17][BIT_OVERLOAD] && st_reg.sum_en[1][3]
		&& st_reg.oper_en[OPER_BIT_SECOND_SUMMARY_GROUP])
		else $error("symbolic enable missed its bit");
endmodule

// *** tb/oseb_host.sv ***
// controller model: drives the bank's bind, clear-status and query ports
// assumes the bench calls one task at a time from a single process
`timescale 1ns/1ps
module oseb_host
	import oseb_pkg::*;
(
	input wire logic clk_i,
	input wire logic query_ack_i,
	output logic bind_valid_o,
	output logic bind_group_o,
	output logic [3:0] bind_member_o,
	output logic [1:0] bind_func_o,
	output logic clear_status_o,
	output logic query_valid_o,
	output logic [1:0] query_op_o,
	output logic [2:0] query_target_o,
	output logic [2:0] query_part_o,
	output logic query_group_o,
	output logic [3:0] query_member_o,
	output logic [2:0] query_symbol_o,
	output logic [15:0] query_wdata_o
);
	logic [31:0] qf_reg = '0;
	logic [6:0] bf_reg = '0;

	assign {query_op_o, query_target_o, query_part_o, query_group_o, query_member_o, query_symbol_o,
		query_wdata_o} = qf_reg;
	assign {bind_group_o, bind_member_o, bind_func_o} = bf_reg;

	initial begin
		bind_valid_o = 1'b0;
		clear_status_o = 1'b0;
		query_valid_o = 1'b0;
	end

	// ----------------------------------------
	// requests
	// ----------------------------------------
	// released fields flip so a stale value never passes for a request
	task automatic query(input logic [1:0] op, input logic [2:0] tgt, input logic [2:0] part, input logic grp,
		input logic [3:0] mem, input logic [2:0] sym, input logic [15:0] wd);
		int n;
		@(posedge clk_i);
		query_valid_o <= 1'b1;
		qf_reg <= {op, tgt, part, grp, mem, sym, wd};
		@(posedge clk_i);
		query_valid_o <= 1'b0;
		qf_reg <= ~qf_reg;
		n = 0;
		while (query_ack_i !== 1'b1 && n < 8) begin
			@(negedge clk_i);
			n++;
		end
	endtask

	// sets sub-register, summary and operation enables in one go
	task automatic sym_enable(input logic grp, input logic [3:0] mem, input logic [2:0] sym);
		query(OP_SYM_ENABLE, TGT_SUBREG, PART_EVENT, grp, mem, sym, 16'h0000);
	endtask

	task automatic bind_sub(input logic grp, input logic [3:0] mem, input logic [1:0] func);
		@(posedge clk_i);
		bind_valid_o <= 1'b1;
		bf_reg <= {grp, mem, func};
		@(posedge clk_i);
		bind_valid_o <= 1'b0;
		bf_reg <= ~bf_reg;
	endtask

	task automatic clear_status();
		@(posedge clk_i);
		clear_status_o <= 1'b1;
		@(posedge clk_i);
		clear_status_o <= 1'b0;
	endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the operation-status event bank
// assumes oseb_pkg and the bank are compiled first; lock tick shortened to 16 cycles
`timescale 1ns/1ps
`define CHK(got, want) begin comparisons++; if ((got) !== (want)) begin n_fail++; $display("mismatch at %0t: got %h expected %h", $time, got, want); end end
module testbench;
	import oseb_pkg::*;
	logic clk_i;
	logic rst_n_i;
	logic [5:0] pins;
	wire logic bv, bg, cs, qv, qg;
	wire logic [3:0] bm, qm;
	wire logic [1:0] bf, qo;
	wire logic [2:0] qt, qp, qs;
	wire logic [15:0] qw;
	logic [15:0] query_rdata_o;
	logic query_ack_o, query_error_o, oper_summary_o, reference_unlocked_flag_o;
	logic [17:0] exp_q[$];
	logic [17:0] e_now;
	logic [31:0] r;
	logic [3:0] mem;
	int n_fail = 0;
	int comparisons = 0;

	oseb_bank #(.LOCK_CHECK_CYCLES_P(16)) oseb_bank_inst (.clk_i, .rst_n_i, .invalid_base_i(pins[0]),
		.invalid_rf_i(pins[1]), .overload_i(pins[2]), .overdrive_i(pins[3]), .underdrive_i(pins[4]),
		.ref_unlocked_i(pins[5]), .bind_valid_i(bv), .bind_group_i(bg), .bind_member_i(bm), .bind_func_i(bf),
		.clear_status_i(cs), .query_valid_i(qv), .query_op_i(qo), .query_target_i(qt), .query_part_i(qp),
		.query_group_i(qg), .query_member_i(qm), .query_symbol_i(qs), .query_wdata_i(qw), .query_rdata_o,
		.query_ack_o, .query_error_o, .oper_summary_o, .reference_unlocked_flag_o);

	oseb_host oseb_host_inst (.clk_i, .query_ack_i(query_ack_o), .bind_valid_o(bv), .bind_group_o(bg),
		.bind_member_o(bm), .bind_func_o(bf), .clear_status_o(cs), .query_valid_o(qv), .query_op_o(qo),
		.query_target_o(qt), .query_part_o(qp), .query_group_o(qg), .query_member_o(qm),
		.query_symbol_o(qs), .query_wdata_o(qw));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// note layout: check-data flag, expected error, expected data
	task automatic ask(input logic [1:0] op, input logic [2:0] tgt, input logic [2:0] part, input logic grp,
		input logic [3:0] m, input logic [15:0] wd, input logic [17:0] e);
		exp_q.push_back(e);
		oseb_host_inst.query(op, tgt, part, grp, m, 3'h0, wd);
	endtask

	task automatic rd(input logic [2:0] tgt, input logic [2:0] part, input logic grp, input logic [3:0] m,
		input logic [15:0] v);
		ask(OP_READ, tgt, part, grp, m, 16'h0000, {2'b10, v});
	endtask

	// pins pass a two-flop synchroniser, so allow settling before looking
	task automatic set_pins(input logic [5:0] v);
		@(posedge clk_i);
		pins <= v;
		repeat (8) @(posedge clk_i);
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic results();
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------
	// clock, monitor, watchdog
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	always @(negedge clk_i) begin
		if (query_ack_o === 1'b1 && exp_q.size() > 0) begin
			e_now = exp_q.pop_front();
			`CHK(query_error_o, e_now[16])
			if (e_now[17])
				`CHK(query_rdata_o, e_now[15:0])
		end else if (query_ack_o === 1'b1)
			`CHK(query_ack_o, 1'b0)
	end

	// the tests need about 300 cycles; allow over ten times that
	initial begin
		#200000;
		n_fail++;
		results();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		rst_n_i = 1'b0;
		pins = 6'h00;
		r = 32'hEB35;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(TGT_SUBREG, PART_PTR, 1'b0, 4'h1, 16'hFFFF);
		rd(TGT_SUBREG, PART_NTR, 1'b0, 4'h1, 16'h0000);
		rd(TGT_SUBREG, PART_ENABLE, 1'b1, 4'hF, 16'h0000);
		ask(OP_WRITE, TGT_QUES, PART_ENABLE, 1'b0, 4'h1, 16'hFFFF, 18'h20000);
		rd(TGT_QUES, PART_ENABLE, 1'b0, 4'h1, 16'h0000);
		ask(OP_READ, TGT_SUBREG, PART_EVENT, 1'b0, 4'h0, 16'h0000, 18'h10000);
		ask(OP_WRITE, TGT_SUBREG, PART_EVENT, 1'b0, 4'h1, 16'h0001, 18'h10000);
		ask(OP_WRITE, TGT_OPER, PART_ENABLE, 1'b0, 4'h1, 16'h0100, 18'h20000);
		rd(TGT_OPER, PART_ENABLE, 1'b0, 4'h1, 16'h0100);
		done("defaults");
		set_pins(6'h01);
		rd(TGT_SUBREG, PART_COND, 1'b0, 4'h1, 16'h0010);
		rd(TGT_SUBREG, PART_EVENT, 1'b0, 4'h1, 16'h0010);
		rd(TGT_SUBREG, PART_EVENT, 1'b0, 4'h1, 16'h0000);
		set_pins(6'h00);
		rd(TGT_SUBREG, PART_EVENT, 1'b0, 4'h1, 16'h0000);
		done("base invalid");
		oseb_host_inst.bind_sub(1'b1, 4'h3, FUNC_RFNS);
		exp_q.push_back(18'h00000);
		oseb_host_inst.sym_enable(1'b1, 4'h3, SYM_OVERLOAD);
		set_pins(6'h1E);
		`CHK(oper_summary_o, 1'b1)
		rd(TGT_SECOND_SUMMARY_GROUP, PART_EVENT, 1'b0, 4'h1, 16'h0008);
		rd(TGT_OPER, PART_EVENT, 1'b0, 4'h1, 16'h0200);
		rd(TGT_SECOND_SUMMARY_GROUP, PART_ENABLE, 1'b0, 4'h1, 16'h0008);
		rd(TGT_SUBREG, PART_ENABLE, 1'b1, 4'h3, 16'h0001);
		rd(TGT_SUBREG, PART_COND, 1'b1, 4'h3, 16'h1811);
		rd(TGT_SUBREG, PART_EVENT, 1'b0, 4'h1, 16'h0000);
		rd(TGT_SUBREG, PART_EVENT, 1'b1, 4'h5, 16'h0000);
		exp_q.push_back(18'h21811);
		oseb_host_inst.query(OP_SYM_READ, TGT_SUBREG, PART_EVENT, 1'b1, 4'h3, SYM_OVERLOAD, 16'h0000);
		repeat (4) @(posedge clk_i);
		`CHK(oper_summary_o, 1'b0)
		set_pins(6'h00);
		rd(TGT_SUBREG, PART_COND, 1'b1, 4'h3, 16'h0000);
		done("rf events");
		set_pins(6'h08);
		set_pins(6'h00);
		oseb_host_inst.clear_status();
		rd(TGT_SUBREG, PART_EVENT, 1'b1, 4'h3, 16'h0000);
		set_pins(6'h08);
		set_pins(6'h00);
		rd(TGT_SUBREG, PART_EVENT, 1'b1, 4'h3, 16'h0800);
		ask(OP_WRITE, TGT_SUBREG, PART_PTR, 1'b1, 4'h3, 16'h0000, 18'h20000);
		ask(OP_WRITE, TGT_SUBREG, PART_NTR, 1'b1, 4'h3, 16'h0800, 18'h20000);
		rd(TGT_SUBREG, PART_NTR, 1'b1, 4'h3, 16'h0800);
		set_pins(6'h08);
		rd(TGT_SUBREG, PART_EVENT, 1'b1, 4'h3, 16'h0000);
		set_pins(6'h00);
		rd(TGT_SUBREG, PART_EVENT, 1'b1, 4'h3, 16'h0800);
		done("clear");
		set_pins(6'h20);
		repeat (24) @(posedge clk_i);
		`CHK(reference_unlocked_flag_o, 1'b1)
		rd(TGT_SUBREG, PART_EVENT, 1'b0, 4'h1, 16'h0040);
		set_pins(6'h00);
		repeat (24) @(posedge clk_i);
		`CHK(reference_unlocked_flag_o, 1'b0)
		done("lock");
		for (int i = 0; i < 6; i++) begin
			r = lfsr(r);
			mem = (r[3:0] == 4'h0) ? 4'h1 : r[3:0];
			ask(OP_WRITE, TGT_SUBREG, PART_ENABLE, r[4], mem, r[31:16], 18'h20000);
			rd(TGT_SUBREG, PART_ENABLE, r[4], mem, r[31:16]);
		end
		done("random enables");
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		`CHK(oper_summary_o, 1'b0)
		rd(TGT_OPER, PART_ENABLE, 1'b0, 4'h1, 16'h0000);
		rd(TGT_SUBREG, PART_PTR, 1'b1, 4'h3, 16'hFFFF);
		done("mid-run reset");
		repeat (4) @(posedge clk_i);
		`CHK(exp_q.size(), 0)
		results();
	end
endmodule
